/* roc_pkg.sv */
// Shared constants and types for the relay output channel controller
package roc_pkg;

    // Channel counts of the two build variants
    localparam int unsigned FOUR_CHANNEL_RELAY_VARIANT  = 4;
    localparam int unsigned EIGHT_CHANNEL_RELAY_VARIANT = 8;
    localparam int unsigned MAX_CH                      = 8;

    // Clock and communication-loss timing
    localparam int unsigned CLOCK_KHZ         = 20000;
    localparam int unsigned COMM_TIMEOUT_MS   = 100;
    localparam int unsigned COMM_TIMEOUT_CYC  = COMM_TIMEOUT_MS * CLOCK_KHZ;

    // Register byte offsets
    localparam logic [5:0] OFS_CTRL      = 6'h00;
    localparam logic [5:0] OFS_PWRUP     = 6'h04;
    localparam logic [5:0] OFS_FAIL      = 6'h08;
    localparam logic [5:0] OFS_LED_SENSE = 6'h0c;
    localparam logic [5:0] OFS_TEST_SEL  = 6'h10;
    localparam logic [5:0] OFS_RELAY     = 6'h14;
    localparam logic [5:0] OFS_DIAG      = 6'h18;
    localparam logic [5:0] OFS_IRQ_STAT  = 6'h1c;
    localparam logic [5:0] OFS_IRQ_MASK  = 6'h20;
    localparam logic [5:0] OFS_VARIANT   = 6'h24;

    // Field positions
    localparam int unsigned CTRL_TEST_BIT    = 0;
    localparam int unsigned DIAG_LOST_BIT    = 3;
    localparam int unsigned IRQ_LOST_BIT     = 0;
    localparam int unsigned IRQ_RESTORE_BIT  = 1;
    localparam int unsigned IRQ_DIAG_BIT     = 2;
    localparam int unsigned IRQ_W            = 3;

    // Fail action codes, two bits per channel
    localparam logic [1:0] FAIL_HOLD = 2'h0;
    localparam logic [1:0] FAIL_ON   = 2'h1;
    localparam logic [1:0] FAIL_OFF  = 2'h2;

    // Reset values
    localparam logic [7:0]  PWRUP_RST = 8'h00;
    localparam logic [15:0] FAIL_RST  = 16'h0000;
    localparam logic        SENSE_RST = 1'h0;

    typedef enum logic [3:0] {
        ST_POWERUP = 4'h1,
        ST_NORMAL  = 4'h2,
        ST_FAILED  = 4'h4,
        ST_TEST    = 4'h8
    } roc_mode_e;

    typedef struct packed {
        roc_mode_e          state;
        logic               ack;
        logic [31:0]        rdata;
        logic               test_en;
        logic [7:0]         pwrup;
        logic [15:0]        fail_mode;
        logic               sense;
        logic [7:0]         relay;
        logic [7:0]         led_red;
        logic [7:0]         led_green;
        logic               comm_lost;
        logic [31:0]        idle_cnt;
        logic [IRQ_W-1:0]   irq_status;
        logic [IRQ_W-1:0]   irq_mask;
        logic [2:0]         diag_prev;
        logic               strobe_prev;
    } roc_state_s;

endpackage

/* roc_sync.sv */
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module roc_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] d_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d_async;
            sync_reg <= meta_reg;
        end
    end

    assign d_sync = sync_reg;
endmodule

/* roc_relay_ctrl.sv */
// Relay output channel controller with Avalon-MM register slave
// Function
// - Four or eight relay channels by build variant, each configured on its own.
// - Per-channel POWERUP_DEFAULT bit energizes that relay at power up, else off; PWRUP register writes are stored only.
// - On lost link each channel holds, forces on, or forces off per setting.
// - LED sense picks red or green for energized; other colour when off.
// - Test mode apply energizes selected relays and de-energizes the rest.
// - Test mode read returns current energized state of every relay.
// - Diagnostic status shows program, working and config memory faults apart.
`timescale 1ns/1ps
module roc_relay_ctrl #(
    parameter int unsigned CHANNELS         = roc_pkg::EIGHT_CHANNEL_RELAY_VARIANT,
    parameter int unsigned COMM_TIMEOUT_CYC = roc_pkg::COMM_TIMEOUT_CYC,
    parameter logic [7:0]  POWERUP_DEFAULT  = roc_pkg::PWRUP_RST,
    parameter logic [15:0] FAIL_DEFAULT     = roc_pkg::FAIL_RST,
    parameter logic        SENSE_DEFAULT    = roc_pkg::SENSE_RST
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // Avalon-MM slave
    input  wire logic [5:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Link from the interface module
    input  wire logic [7:0]  LINK_VALUE,
    input  wire logic        LINK_STROBE,
    // Memory self-test results
    input  wire logic        PROG_MEM_FAIL,
    input  wire logic        WORK_MEM_FAIL,
    input  wire logic        CFG_CSUM_ERR,
    // Relay drives and LEDs
    output logic      [7:0]  RELAY_ON,
    output logic      [7:0]  LED_RED,
    output logic      [7:0]  LED_GREEN,
    // Interrupt
    output logic             IRQ
);
    localparam logic [7:0] CH_MASK = 8'((16'h1 << CHANNELS) - 16'h1);
    localparam logic [7:0] RELAY_RST = POWERUP_DEFAULT & CH_MASK;

    localparam roc_pkg::roc_state_s RESET_VAL = '{
        state:       roc_pkg::ST_POWERUP,
        ack:         1'h0,
        rdata:       32'h0,
        test_en:     1'h0,
        pwrup:       POWERUP_DEFAULT & CH_MASK,
        fail_mode:   FAIL_DEFAULT,
        sense:       SENSE_DEFAULT,
        relay:       RELAY_RST,
        led_red:     (RELAY_RST ^ {8{SENSE_DEFAULT}}) & CH_MASK,
        led_green:   (RELAY_RST ~^ {8{SENSE_DEFAULT}}) & CH_MASK,
        comm_lost:   1'h0,
        idle_cnt:    32'h0,
        irq_status:  '0,
        irq_mask:    '0,
        diag_prev:   3'h0,
        strobe_prev: 1'h0
    };

    // Fail action applied to every channel
    function automatic logic [7:0] fail_apply(input logic [7:0]  cur,
                                              input logic [15:0] mode);
        logic [7:0] res;
        res = cur;
        for (int i = 0; i < 8; i++) begin
            if (mode[2*i +: 2] == roc_pkg::FAIL_ON) begin
                res[i] = 1'b1;
            end else if (mode[2*i +: 2] == roc_pkg::FAIL_OFF) begin
                res[i] = 1'b0;
            end
        end
        return res;
    endfunction

    // Reset release
    logic rst_meta_reg;
    logic rst_n_sync;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    // Pin inputs into the clock domain
    logic [11:0] pins_sync;
    logic [7:0]  link_val;
    logic        link_strobe;
    logic [2:0]  diag_now;

    roc_sync #(
        .W       (12)
    ) u_sync (
        .clk     (CLOCK),
        .rst_n   (rst_n_sync),
        .d_async ({CFG_CSUM_ERR, WORK_MEM_FAIL, PROG_MEM_FAIL, LINK_STROBE, LINK_VALUE}),
        .d_sync  (pins_sync)
    );

    assign link_val    = pins_sync[7:0];
    assign link_strobe = pins_sync[8];
    assign diag_now    = pins_sync[11:9];

    roc_pkg::roc_state_s st_reg;
    roc_pkg::roc_state_s st_next;

    logic       accept;
    logic       wr_acc;
    logic       rd_acc;
    logic       strobe_evt;
    localparam int unsigned IRQ_W_T = roc_pkg::IRQ_W;
    logic       lost_now;
    logic [IRQ_W_T-1:0] irq_evt;

    // One wait state; a write lands at the edge where waitrequest is low
    assign accept          = (AVS_READ | AVS_WRITE) & ~st_reg.ack;
    assign wr_acc          = AVS_WRITE & st_reg.ack;
    assign rd_acc          = accept & AVS_READ;
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st_reg.ack;
    assign strobe_evt      = link_strobe & ~st_reg.strobe_prev;

    always_comb begin
        st_next = st_reg;
        st_next.ack = accept;
        st_next.strobe_prev = link_strobe;
        st_next.diag_prev = diag_now;

        // Link watchdog
        if (strobe_evt) begin
            st_next.idle_cnt = 32'h0;
            st_next.comm_lost = 1'b0;
        end else if (st_reg.idle_cnt != 32'(COMM_TIMEOUT_CYC)) begin
            st_next.idle_cnt = st_reg.idle_cnt + 32'h1;
        end
        if (st_next.idle_cnt == 32'(COMM_TIMEOUT_CYC)) begin
            st_next.comm_lost = 1'b1;
        end
        lost_now = st_next.comm_lost & ~st_reg.comm_lost;

        // Register writes
        if (wr_acc) begin
            case (AVS_ADDRESS)
                roc_pkg::OFS_CTRL: begin
                    st_next.test_en = AVS_WRITEDATA[roc_pkg::CTRL_TEST_BIT];
                end
                roc_pkg::OFS_PWRUP: begin
                    st_next.pwrup = AVS_WRITEDATA[7:0] & CH_MASK;
                end
                roc_pkg::OFS_FAIL: begin
                    st_next.fail_mode = AVS_WRITEDATA[15:0];
                end
                roc_pkg::OFS_LED_SENSE: begin
                    st_next.sense = AVS_WRITEDATA[0];
                end
                roc_pkg::OFS_IRQ_MASK: begin
                    st_next.irq_mask = AVS_WRITEDATA[IRQ_W_T-1:0];
                end
                default: begin
                end
            endcase
        end

        // Relay mode machine
        case (st_reg.state)
            roc_pkg::ST_POWERUP, roc_pkg::ST_NORMAL, roc_pkg::ST_FAILED: begin
                if (st_reg.test_en) begin
                    st_next.state = roc_pkg::ST_TEST;
                end else if (strobe_evt) begin
                    st_next.state = roc_pkg::ST_NORMAL;
                    st_next.relay = link_val;
                end else if (lost_now) begin
                    st_next.state = roc_pkg::ST_FAILED;
                    st_next.relay = fail_apply(st_reg.relay, st_reg.fail_mode);
                end
            end
            roc_pkg::ST_TEST: begin
                if (!st_reg.test_en) begin
                    st_next.state = st_reg.comm_lost ? roc_pkg::ST_FAILED : roc_pkg::ST_NORMAL;
                end else if (wr_acc && AVS_ADDRESS == roc_pkg::OFS_TEST_SEL) begin
                    st_next.relay = AVS_WRITEDATA[7:0];
                end
            end
            default: begin
                st_next.state = roc_pkg::ST_POWERUP;
            end
        endcase
        st_next.relay = st_next.relay & CH_MASK;

        // LED colour follows relay state and sense
        st_next.led_red   = (st_reg.relay ^ {8{st_reg.sense}}) & CH_MASK;
        st_next.led_green = (st_reg.relay ~^ {8{st_reg.sense}}) & CH_MASK;

        // Sticky events, set wins over read-clear
        irq_evt = '0;
        irq_evt[roc_pkg::IRQ_LOST_BIT]    = lost_now;
        irq_evt[roc_pkg::IRQ_RESTORE_BIT] = strobe_evt & st_reg.comm_lost;
        irq_evt[roc_pkg::IRQ_DIAG_BIT]    = |(diag_now & ~st_reg.diag_prev);
        if (rd_acc && AVS_ADDRESS == roc_pkg::OFS_IRQ_STAT) begin
            st_next.irq_status = irq_evt;
        end else begin
            st_next.irq_status = st_reg.irq_status | irq_evt;
        end

        // Read data, zero for unmapped offsets
        if (rd_acc) begin
            case (AVS_ADDRESS)
                roc_pkg::OFS_CTRL:      st_next.rdata = {31'h0, st_reg.test_en};
                roc_pkg::OFS_PWRUP:     st_next.rdata = {24'h0, st_reg.pwrup};
                roc_pkg::OFS_FAIL:      st_next.rdata = {16'h0, st_reg.fail_mode};
                roc_pkg::OFS_LED_SENSE: st_next.rdata = {31'h0, st_reg.sense};
                roc_pkg::OFS_TEST_SEL,
                roc_pkg::OFS_RELAY:     st_next.rdata = {24'h0, st_reg.relay};
                roc_pkg::OFS_DIAG:      st_next.rdata = {28'h0, st_reg.comm_lost,
                                                         diag_now};
                roc_pkg::OFS_IRQ_STAT:  st_next.rdata = 32'(st_reg.irq_status);
                roc_pkg::OFS_IRQ_MASK:  st_next.rdata = 32'(st_reg.irq_mask);
                roc_pkg::OFS_VARIANT:   st_next.rdata = 32'(CHANNELS);
                default:                st_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_reg <= RESET_VAL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign AVS_READDATA = st_reg.rdata;
    assign RELAY_ON     = st_reg.relay;
    assign LED_RED      = st_reg.led_red;
    assign LED_GREEN    = st_reg.led_green;
    assign IRQ          = |(st_reg.irq_status & st_reg.irq_mask);

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_n_sync);

    a_chan_mask: assert property (
        (st_reg.relay & ~CH_MASK) == 8'h0 && (LED_GREEN & ~CH_MASK) == 8'h0)
        else $error("relay or LED driven on an absent channel");

    a_powerup_hold: assert property (
        st_reg.state == roc_pkg::ST_POWERUP |-> st_reg.relay == RELAY_RST)
        else $error("relay left power-up state before first link update");

    a_link_drive: assert property (
        strobe_evt && !st_reg.test_en && st_reg.state != roc_pkg::ST_TEST
        |=> RELAY_ON == ($past(link_val) & CH_MASK))
        else $error("link value not applied to relays");

    a_timeout_lost: assert property (
        st_reg.idle_cnt == 32'(COMM_TIMEOUT_CYC - 1) && !strobe_evt
        |=> st_reg.comm_lost && $rose(st_reg.comm_lost))
        else $error("link loss not flagged at timeout");

    a_fail_action: assert property (
        lost_now && !st_reg.test_en && st_reg.state != roc_pkg::ST_TEST
        |=> RELAY_ON == (fail_apply($past(st_reg.relay), $past(st_reg.fail_mode)) & CH_MASK))
        else $error("fail action not applied on link loss");

    a_led_sense: assert property (
        ##1 LED_GREEN == (($past(st_reg.relay) ~^ {8{$past(st_reg.sense)}}) & CH_MASK)
        && LED_RED == (~LED_GREEN & CH_MASK))
        else $error("LED colour does not follow relay and sense");

    a_test_apply: assert property (
        st_reg.state == roc_pkg::ST_TEST && st_reg.test_en && wr_acc
        && AVS_ADDRESS == roc_pkg::OFS_TEST_SEL
        |=> RELAY_ON == ($past(AVS_WRITEDATA[7:0]) & CH_MASK))
        else $error("test selection not applied");

    a_test_read: assert property (
        rd_acc && AVS_ADDRESS == roc_pkg::OFS_RELAY
        |=> !AVS_WAITREQUEST && AVS_READDATA == {24'h0, $past(st_reg.relay)})
        else $error("relay state read back wrong");

    a_diag_read: assert property (
        rd_acc && AVS_ADDRESS == roc_pkg::OFS_DIAG
        |=> AVS_READDATA[2:0] == $past(diag_now))
        else $error("diagnostic bits read back wrong");

    a_lost_read: assert property (
        rd_acc && AVS_ADDRESS == roc_pkg::OFS_DIAG
        |=> AVS_READDATA[roc_pkg::DIAG_LOST_BIT] == $past(st_reg.comm_lost))
        else $error("link loss bit read back wrong");

    a_irq_raise: assert property (
        lost_now && st_reg.irq_mask[roc_pkg::IRQ_LOST_BIT]
        && !(wr_acc && AVS_ADDRESS == roc_pkg::OFS_IRQ_MASK) |=> IRQ)
        else $error("loss interrupt not raised");

    a_irq_set_wins: assert property (
        lost_now && rd_acc && AVS_ADDRESS == roc_pkg::OFS_IRQ_STAT
        |=> st_reg.irq_status[roc_pkg::IRQ_LOST_BIT])
        else $error("loss event dropped by a clearing read");

    a_irq_clear: assert property (
        !lost_now && rd_acc && AVS_ADDRESS == roc_pkg::OFS_IRQ_STAT
        |=> !st_reg.irq_status[roc_pkg::IRQ_LOST_BIT])
        else $error("status read did not clear loss bit");

    a_restore_flag: assert property (
        strobe_evt && st_reg.comm_lost
        |=> !st_reg.comm_lost && st_reg.irq_status[roc_pkg::IRQ_RESTORE_BIT])
        else $error("link restore not flagged");

    a_test_enter: assert property (
        st_reg.test_en && st_reg.state != roc_pkg::ST_TEST
        |=> st_reg.state == roc_pkg::ST_TEST)
        else $error("test mode not entered");

    a_test_hold: assert property (
        st_reg.state == roc_pkg::ST_TEST
        && !(wr_acc && AVS_ADDRESS == roc_pkg::OFS_TEST_SEL)
        |=> $stable(RELAY_ON))
        else $error("relays moved in test mode without a selection");

    a_pwrup_store: assert property (
        wr_acc && AVS_ADDRESS == roc_pkg::OFS_PWRUP
        |=> st_reg.pwrup == ($past(AVS_WRITEDATA[7:0]) & CH_MASK))
        else $error("power-up flags not stored");

    a_fail_store: assert property (
        wr_acc && AVS_ADDRESS == roc_pkg::OFS_FAIL
        |=> st_reg.fail_mode == $past(AVS_WRITEDATA[15:0]))
        else $error("fail settings not stored");

    a_sense_store: assert property (
        wr_acc && AVS_ADDRESS == roc_pkg::OFS_LED_SENSE
        |=> st_reg.sense == $past(AVS_WRITEDATA[0]))
        else $error("LED sense not stored");

    c_link_lost: cover property (lost_now ##1 st_reg.state == roc_pkg::ST_FAILED);
    c_test_apply: cover property (st_reg.state == roc_pkg::ST_TEST && wr_acc);
    c_link_update: cover property (st_reg.state == roc_pkg::ST_NORMAL && strobe_evt);
    c_irq_raise: cover property ($rose(IRQ));
    c_test_read: cover property (st_reg.state == roc_pkg::ST_TEST && rd_acc);
endmodule

/* roc_link_model.sv */
// Behavioural interface-module side that sends channel values over the link
`timescale 1ns/1ps
module roc_link_model (
    // Clock
    input  wire logic       clk,
    // Link pins
    output logic      [7:0] link_value,
    output logic            link_strobe
);
    initial begin
        link_value  = 8'h00;
        link_strobe = 1'b0;
    end

    // Value set up first, held well past the strobe, then left to drift
    task automatic send(input logic [7:0] v, input int slow);
        @(posedge clk);
        link_value <= v;
        repeat (1 + slow) @(posedge clk);
        link_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        link_strobe <= 1'b0;
        repeat (3) @(posedge clk);
        link_value <= ~v;
    endtask
endmodule

/* tb_relay_output_channel_ctrl.sv */
// Self-checking testbench for the relay output channel controller
`timescale 1ns/1ps
module tb_relay_output_channel_ctrl;
    localparam logic [7:0]  PWR_DEF  = 8'ha5;
    localparam logic [15:0] FAIL_CFG = 16'he4e4;
    localparam int          TMO      = 5000;
    logic        CLOCK;
    logic        RST_N;
    logic [5:0]  addr;
    logic        rd_r;
    logic        wr_r;
    logic [31:0] wdat;
    logic [31:0] rdata;
    logic        wait_r;
    logic [7:0]  link_v;
    logic        link_s;
    logic        pf;
    logic        wf;
    logic        cf;
    logic [7:0]  relay;
    logic [7:0]  led_r;
    logic [7:0]  led_g;
    logic        irq;
    logic [31:0] r;
    logic [7:0]  v;
    int          errors;
    int          checks_done;
    int          cyc = 0;
    int          n;
    int          model_relay;

    roc_relay_ctrl #(.CHANNELS(8), .COMM_TIMEOUT_CYC(50), .POWERUP_DEFAULT(PWR_DEF))
    i_roc_relay_ctrl (.CLOCK(CLOCK), .RST_N(RST_N), .AVS_ADDRESS(addr), .AVS_READ(rd_r),
        .AVS_WRITE(wr_r), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_r), .LINK_VALUE(link_v), .LINK_STROBE(link_s),
        .PROG_MEM_FAIL(pf), .WORK_MEM_FAIL(wf), .CFG_CSUM_ERR(cf), .RELAY_ON(relay),
        .LED_RED(led_r), .LED_GREEN(led_g), .IRQ(irq));

    roc_link_model i_roc_link_model (.clk(CLOCK), .link_value(link_v), .link_strobe(link_s));

    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One Avalon transfer; held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        addr <= a;
        wdat <= d;
        rd_r <= !w;
        wr_r <= w;
        do @(posedge CLOCK); while (wait_r !== 1'b0);
        r = rdata;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
    endtask

    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(r, exp, "register read");
    endtask

    function automatic logic [7:0] fail_exp(input logic [7:0] last);
        logic [7:0] e;
        for (int ch = 0; ch < 8; ch++) begin
            case (FAIL_CFG[2*ch +: 2])
                roc_pkg::FAIL_ON:  e[ch] = 1'b1;
                roc_pkg::FAIL_OFF: e[ch] = 1'b0;
                default:           e[ch] = last[ch];
            endcase
        end
        return e;
    endfunction

    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == TMO) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        RST_N = 1'b0; addr = 6'h00; rd_r = 1'b0; wr_r = 1'b0; wdat = 32'h0;
        pf = 1'b0; wf = 1'b0; cf = 1'b0; errors = 0; checks_done = 0;
        r = $urandom(3);
        repeat (5) @(posedge CLOCK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLOCK);
        @(negedge CLOCK);
        chk(relay, PWR_DEF, "power-up relays");
        chk(led_r, PWR_DEF, "power-up red");
        chk(led_g, 8'(~PWR_DEF), "power-up green");
        rdchk(roc_pkg::OFS_VARIANT, 32'h8);
        rdchk(6'h3c, 32'h0);
        rdchk(roc_pkg::OFS_FAIL, roc_pkg::FAIL_RST);
        bus(1'b1, roc_pkg::OFS_PWRUP, 32'h3c);
        rdchk(roc_pkg::OFS_PWRUP, 32'h3c);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            model_relay = $urandom & 32'hff;
            i_roc_link_model.send(model_relay[7:0], $urandom % 4);
            @(negedge CLOCK);
            chk(relay, model_relay, "link value");
        end
        bus(1'b1, roc_pkg::OFS_LED_SENSE, 32'h1);
        repeat (2) @(negedge CLOCK);
        chk(led_g, model_relay, "green sense");
        chk(led_r, 8'(~model_relay[7:0]), "red off");
        $display("test link done");
        bus(1'b1, roc_pkg::OFS_FAIL, {16'h0, FAIL_CFG});
        bus(1'b1, roc_pkg::OFS_IRQ_MASK, 32'h1);
        rdchk(roc_pkg::OFS_FAIL, {16'h0, FAIL_CFG});
        model_relay = 32'h5a;
        i_roc_link_model.send(8'h5a, 0);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(negedge CLOCK);
            n++;
        end
        chk(irq, 1'b1, "loss interrupt");
        repeat (3) @(negedge CLOCK);
        chk(relay, fail_exp(8'h5a), "fail action");
        rdchk(roc_pkg::OFS_DIAG, 32'h8);
        rdchk(roc_pkg::OFS_IRQ_STAT, 32'h1);
        @(negedge CLOCK);
        chk(irq, 1'b0, "interrupt cleared");
        model_relay = $urandom & 32'hff;
        i_roc_link_model.send(model_relay[7:0], 1);
        @(negedge CLOCK);
        chk(relay, model_relay, "restored link");
        chk(irq, 1'b0, "masked restore");
        rdchk(roc_pkg::OFS_IRQ_STAT, 32'h2);
        $display("test fail done");
        bus(1'b1, roc_pkg::OFS_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            v = 8'($urandom);
            bus(1'b1, roc_pkg::OFS_TEST_SEL, {24'h0, v});
            rdchk(roc_pkg::OFS_TEST_SEL, {24'h0, v});
            chk(relay, v, "test apply");
        end
        i_roc_link_model.send(~v, 0);
        @(negedge CLOCK);
        chk(relay, v, "link ignored in test");
        bus(1'b1, roc_pkg::OFS_CTRL, 32'h0);
        $display("test output test done");
        for (int i = 0; i < 3; i++) begin
            @(posedge CLOCK);
            {cf, wf, pf} <= 3'h1 << i;
            repeat (4) @(posedge CLOCK);
            bus(1'b0, roc_pkg::OFS_DIAG, 32'h0);
            chk(r[2:0], 3'h1 << i, "diag fault");
        end
        {cf, wf, pf} <= 3'h0;
        rdchk(roc_pkg::OFS_IRQ_STAT, 32'h4);
        $display("test diag done");
        report_and_stop();
    end
endmodule
